//--- fpm_defines.svh
// Timing, width and field constants for the page memory host controller.
// Assumes a 20 MHz system clock; all counts are derived from nanosecond figures.
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH

// ****************************************
// Clock
// ****************************************
`define FPM_CLK_PERIOD_NS 50

// ****************************************
// Address layout
// ****************************************
`define FPM_ADDR_W 17
`define FPM_DATA_W 8
`define FPM_COL_W 3
`define FPM_ROWS 16384
`define FPM_BYTES 131072

// ****************************************
// Timing figures and derived cycle counts
// ****************************************
`define FPM_ACCESS_TIME_NS 60
`define FPM_RANDOM_READ_CYCLE_TIME_NS 90
`define FPM_RANDOM_WRITE_CYCLE_TIME_NS 90
`define FPM_PRECHARGE_MIN_TIME_NS 30
`define FPM_COL_STABLE_NS 15
`define FPM_DATA_SETUP_NS 20
// Least times round up
`define FPM_CYC(ns) (((ns) + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`define FPM_ACCESS_CYC `FPM_CYC(`FPM_ACCESS_TIME_NS)
`define FPM_RC_CYC `FPM_CYC(`FPM_RANDOM_READ_CYCLE_TIME_NS)
`define FPM_WC_CYC `FPM_CYC(`FPM_RANDOM_WRITE_CYCLE_TIME_NS)
`define FPM_PC_CYC `FPM_CYC(`FPM_PRECHARGE_MIN_TIME_NS)
`define FPM_COL_CYC `FPM_CYC(`FPM_COL_STABLE_NS)
`define FPM_SETUP_CYC `FPM_CYC(`FPM_DATA_SETUP_NS)

`endif

//--- fpm_pkg.sv
// Types shared by the page memory host controller.
// Assumes fpm_defines.svh sets the widths.
`include "fpm_defines.svh"
package fpm_pkg;
	// Request from the user side
	typedef struct packed {
		logic write;
		logic [`FPM_ADDR_W-1:0] addr;
		logic [`FPM_DATA_W-1:0] wdata;
	} fpm_req_type;

	// Control pins towards the memory
	typedef struct packed {
		logic selLowN;
		logic selHigh;
		logic writeStrobeN;
		logic outputDriveN;
	} fpm_pins_type;

	// Gray coded along idle, setup, access, strobe-release, hold, precharge
	typedef enum logic [2:0] {
		FPM_IDLE = 3'h0,
		FPM_SETUP = 3'h1,
		FPM_ACCESS = 3'h3,
		FPM_FINISH = 3'h2,
		FPM_SPACE = 3'h6,
		FPM_PRECH = 3'h7
	} fpm_state_type;
endpackage

//--- fpm_sync.sv
// Two-stage synchroniser for the data bus read back from the memory.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/10ps
module fpm_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	// ****************************************
	// Synchroniser
	// ****************************************
	// First stage feeds only the second one
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else if (clkEn) begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;
endmodule

//--- fpm_host.sv
// Host controller that drives a bytewide nonvolatile page memory through its pins.
// Assumes the memory sits on the same board with its data pins sampled through two flip-flops.
// Notes on behaviour
// RULE1 - 128K bytes: 16K rows, eight columns
// RULE2 - Address latched on select activation
// RULE3 - Deselect starts row precharge
// RULE4 - One write strobe pulse per byte
// RULE5 - Strobe high at select means read
// RULE6 - Space random accesses by read cycle
// RULE7 - Device drives only after access completes
// RULE8 - Output drive high keeps bus floating
// RULE9 - Strobe low at select: write cycle
// RULE10 - Data valid when select ends write
// RULE11 - Strobe-controlled write releases device bus
// RULE12 - Write ends at first strobe deassertion
// RULE13 - Meet access and setup before ending
// RULE14 - No busy period after writes
// RULE15 - Page read changes column only
// RULE16 - Page write: pulse per new column
// RULE17 - Hold select inactive for precharge time
// RULE18 - Row change reopens row automatically
// RULE19 - Random writes spaced by write cycle
// RULE20 - Whole row opened per access
// RULE21 - Write data captured at first end
// RULE22 - Column captured on strobe fall
// RULE23 - Keep column stable fifteen nanoseconds
// RULE24 - Deselected device ignores everything
`timescale 1ns/10ps
`include "fpm_defines.svh"
module fpm_host
	import fpm_pkg::*;
#(
	parameter int ADDR_W = `FPM_ADDR_W,
	parameter int DATA_W = `FPM_DATA_W,
	parameter int ACCESS_CYC = `FPM_ACCESS_CYC,
	parameter int PC_CYC = `FPM_PC_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire fpm_req_type req,
	output logic reqReady,
	output logic rspValid,
	output logic [DATA_W-1:0] rspData,
	output logic selLowN,
	output logic selHigh,
	output logic writeStrobeN,
	output logic outputDriveN,
	output logic [ADDR_W-1:0] addrOut,
	input wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOeN
);
	localparam int CNT_W = 4;
	localparam int COL_W = `FPM_COL_W;
	// Row change after a one-cycle deselect needs a full random cycle; page hits need column stability
	localparam int RC_CYC = (`FPM_RC_CYC > `FPM_WC_CYC) ? `FPM_RC_CYC : `FPM_WC_CYC;
	localparam int COL_CYC = `FPM_COL_CYC;
	// Two sync stages delay read data
	localparam int SYNC_CYC = 2;

	fpm_state_type state_reg, state_next;
	fpm_pins_type pins_reg, pins_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic write_reg, write_next;
	logic oeN_reg, oeN_next;
	logic ready_reg, ready_next;
	logic rsp_reg, rsp_next;
	logic open_reg, open_next;
	logic [DATA_W-1:0] dataSync;

	// ****************************************
	// Helper functions
	// ****************************************
	// Row part of an address: the column bits are dropped [RULE1]
	function automatic logic [ADDR_W-COL_W-1:0] rowOf(input logic [ADDR_W-1:0] a);
		rowOf = a[ADDR_W-1:COL_W];
	endfunction

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction

	// ****************************************
	// Read data crossing
	// ****************************************
	fpm_sync #(
		.WIDTH(DATA_W)
	) uSync (
		.clk_sys(clk_sys),
		.srst(srst),
		.clkEn(clkEn),
		.asyncIn(dataIn),
		.syncOut(dataSync)
	);

	// Page hit keeps the row open and the selects active
	wire logic acceptReq = ready_reg && reqValid;
	wire logic pageHit = open_reg && (rowOf(req.addr) == rowOf(addr_reg)); // [RULE15] [RULE16] [RULE20]
	wire logic cntDone = (cnt_reg == '0);
	wire logic [CNT_W-1:0] cntDec = cnt_reg - cyc(1);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		pins_next = pins_reg;
		cnt_next = cntDone ? cnt_reg : cntDec;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		write_next = write_reg;
		oeN_next = oeN_reg;
		ready_next = 1'b0;
		rsp_next = 1'b0;
		open_next = open_reg;
		case (state_reg)
			FPM_IDLE: begin
				ready_next = 1'b1;
				if (acceptReq) begin
					ready_next = 1'b0;
					addr_next = req.addr;
					wdata_next = req.wdata;
					write_next = req.write;
					if (pageHit) begin
						// Column change only, row stays open [RULE15] [RULE18]
						pins_next.writeStrobeN = ~req.write; // [RULE22]
						pins_next.outputDriveN = req.write;
						oeN_next = ~req.write;
						cnt_next = cyc(ACCESS_CYC + SYNC_CYC);
						state_next = FPM_ACCESS;
					end else begin
						// Address settles one cycle before the select falls [RULE2]
						pins_next.selLowN = 1'b1;
						pins_next.selHigh = 1'b1;
						state_next = FPM_SETUP;
					end
				end else if (open_reg) begin
					// Nothing pending: close the row by deselecting [RULE3] [RULE24]
					pins_next.selLowN = 1'b1;
					pins_next.outputDriveN = 1'b1;
					open_next = 1'b0;
					cnt_next = cyc(PC_CYC);
					state_next = FPM_PRECH;
				end
			end
			FPM_SETUP: begin
				// Strobe state at select defines read or write [RULE5] [RULE9]
				pins_next.selLowN = 1'b0;
				pins_next.writeStrobeN = ~write_reg; // [RULE4]
				pins_next.outputDriveN = write_reg; // [RULE8] [RULE11]
				oeN_next = ~write_reg;
				open_next = 1'b1;
				cnt_next = cyc(RC_CYC + SYNC_CYC); // [RULE6] [RULE19]
				state_next = FPM_ACCESS;
			end
			FPM_ACCESS: begin
				// Wait access time; also covers data setup [RULE13] [RULE7]
				if (cntDone) begin
					if (write_reg) begin
						pins_next.writeStrobeN = 1'b1; // [RULE12] [RULE21] [RULE10]
					end else begin
						rdata_next = dataSync;
						pins_next.outputDriveN = 1'b1;
					end
					cnt_next = cyc(COL_CYC);
					state_next = FPM_FINISH;
				end
			end
			FPM_FINISH: begin
				// Write data held one cycle past strobe rise; no busy poll [RULE14]
				oeN_next = 1'b1;
				rsp_next = 1'b1;
				state_next = FPM_SPACE;
			end
			FPM_SPACE: begin
				// Column stays stable before the next change [RULE23]
				if (cntDone) begin
					ready_next = 1'b1;
					state_next = FPM_IDLE;
				end
			end
			FPM_PRECH: begin
				// Select stays inactive for the precharge time [RULE17]
				if (cntDone) begin
					ready_next = 1'b1;
					state_next = FPM_IDLE;
				end
			end
			default: begin
				state_next = FPM_IDLE;
			end
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	// Low select starts inactive so the memory ignores the bus during reset [RULE24]
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= FPM_IDLE;
			pins_reg <= '{selLowN: 1'b1, selHigh: 1'b1, writeStrobeN: 1'b1, outputDriveN: 1'b1};
			cnt_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			write_reg <= 1'b0;
			oeN_reg <= 1'b1;
			ready_reg <= 1'b0;
			rsp_reg <= 1'b0;
			open_reg <= 1'b0;
		end else if (clkEn) begin
			state_reg <= state_next;
			pins_reg <= pins_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			write_reg <= write_next;
			oeN_reg <= oeN_next;
			ready_reg <= ready_next;
			rsp_reg <= rsp_next;
			open_reg <= open_next;
		end
	end

	// Outputs come straight from flip-flops
	assign reqReady = ready_reg;
	assign rspValid = rsp_reg;
	assign rspData = rdata_reg;
	assign selLowN = pins_reg.selLowN;
	assign selHigh = pins_reg.selHigh;
	assign writeStrobeN = pins_reg.writeStrobeN;
	assign outputDriveN = pins_reg.outputDriveN;
	assign addrOut = addr_reg;
	assign dataOut = wdata_reg;
	assign dataOeN = oeN_reg;
endmodule

//--- fpm_mem_model.sv
// Behavioural model of the page memory as seen from its pins.
// Assumes the testbench resolves the shared data wire from both enables.
`timescale 1ns/10ps
module fpm_mem_model (
	input wire logic selLowN,
	input wire logic selHigh,
	input wire logic writeStrobeN,
	input wire logic outputDriveN,
	input wire logic [16:0] addrIn,
	input wire logic [7:0] dqIn,
	output logic [7:0] dqOut,
	output logic dqEn
);
	// ****************
	// Array and access state
	// ****************
	logic [7:0] mem [0:131071]; // Survives host resets
	logic [16:0] latchAddr = 17'h00000;
	logic accDone = 1'h0;
	wire selected = !selLowN && selHigh;
	wire [16:0] curAddr = {latchAddr[16:3], addrIn[2:0]};
	// Latch on activation; data valid only after the access time
	always @(negedge selLowN) begin
		if (selHigh) begin
			latchAddr = addrIn;
			accDone <= #60 1'h1;
		end
	end
	// Deselect closes the row and ends a select-held write
	always @(posedge selLowN) begin
		if (!writeStrobeN) mem[curAddr] = dqIn;
		accDone = 1'h0;
	end
	always @(posedge writeStrobeN) if (selected) mem[curAddr] = dqIn;
	// Never drives during a write or while deselected
	assign dqEn = selected && accDone && !outputDriveN && writeStrobeN;
	assign dqOut = mem[curAddr];
endmodule

//--- fpm_host_checker.sv
// Pin protocol assertions for the page memory host.
// Assumes it is bound to fpm_host and clkEn only drops while no access is in flight.
`timescale 1ns/10ps
module fpm_host_checker
	import fpm_pkg::*;
#(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 8,
	parameter int ACCESS_CYC = 2,
	parameter int PC_CYC = 1
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire fpm_req_type req,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic [DATA_W-1:0] rspData,
	input wire logic selLowN,
	input wire logic selHigh,
	input wire logic writeStrobeN,
	input wire logic outputDriveN,
	input wire logic [ADDR_W-1:0] addrOut,
	input wire logic [DATA_W-1:0] dataIn,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic dataOeN
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_sel_read;
		$fell(selLowN) && writeStrobeN;
	endsequence
	// Strobe low for the full access time
	sequence s_strobe_low;
		$fell(writeStrobeN) ##1 !writeStrobeN;
	endsequence
	a_reset_quiet: assert property ($fell(srst) |-> selLowN && writeStrobeN && outputDriveN && dataOeN && !rspValid)
		else $error("pins active out of reset");
	a_high_tied: assert property (selHigh) else $error("high select dropped");
	a_read_done: assert property (s_sel_read |-> ##[2:8] rspValid) else $error("read not done");
	a_strobe_pulse: assert property (s_strobe_low |-> ##[1:8] $rose(writeStrobeN) ##[0:2] rspValid)
		else $error("write pulse wrong");
	a_data_setup: assert property ($rose(writeStrobeN) |-> !dataOeN && $stable(dataOut))
		else $error("write data not held");
	a_no_clash: assert property (!outputDriveN |-> dataOeN && writeStrobeN && !selLowN)
		else $error("bus clash");
	a_rsp_single: assert property (rspValid |-> !reqReady ##1 !rspValid) else $error("response too long");
	a_row_fixed: assert property (!selLowN && $past(selLowN) == 1'h0 |-> addrOut[ADDR_W-1:3] == $past(addrOut[ADDR_W-1:3]))
		else $error("row moved while selected");
	a_idle_quiet: assert property (selLowN |-> outputDriveN && writeStrobeN) else $error("strobe while idle");
endmodule
bind fpm_host fpm_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .ACCESS_CYC(ACCESS_CYC), .PC_CYC(PC_CYC)) chk_i (
	.clk_sys, .srst, .clkEn, .reqValid, .req, .reqReady, .rspValid, .rspData, .selLowN, .selHigh,
	.writeStrobeN, .outputDriveN, .addrOut, .dataIn, .dataOut, .dataOeN);

//--- fpm_host_tb.sv
// Self-checking bench for the page memory host with a pin-level memory model.
// Assumes default timing parameters and a 50 ns clock.
`timescale 1ns/10ps
module fpm_host_tb
	import fpm_pkg::*;
;
	typedef struct packed {logic w; logic [16:0] a; logic [7:0] d;} fpm_row_type;
	logic clk_sys, srst, clkEn, reqValid, reqReady, rspValid, selLowN, selHigh, writeStrobeN, outputDriveN, dataOeN, memEn;
	fpm_req_type req;
	logic [16:0] addrOut;
	logic [7:0] rspData, dataOut, memDq, dqPrev;
	int n_errors = 0;
	int cmp_count = 0;
	// Released wire toggles so a stale value never reads as good
	wire [7:0] dqWire = !dataOeN ? dataOut : memEn ? memDq : ~dqPrev;
	fpm_row_type rows [9] = '{'{1'h1, 17'h00000, 8'ha5}, '{1'h1, 17'h00001, 8'h3c}, '{1'h1, 17'h1ffff, 8'h5a},
		'{1'h1, 17'h1fff8, 8'hc3}, '{1'h1, 17'h00008, 8'he7}, '{1'h0, 17'h00000, 8'ha5},
		'{1'h0, 17'h1ffff, 8'h5a}, '{1'h0, 17'h00001, 8'h3c}, '{1'h0, 17'h1fff8, 8'hc3}};
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) dqPrev <= dqWire;
	fpm_host DUT (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .reqValid(reqValid), .req(req), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData), .selLowN(selLowN), .selHigh(selHigh), .writeStrobeN(writeStrobeN),
		.outputDriveN(outputDriveN), .addrOut(addrOut), .dataIn(dqWire), .dataOut(dataOut), .dataOeN(dataOeN));
	fpm_mem_model mem_i (.selLowN(selLowN), .selHigh(selHigh), .writeStrobeN(writeStrobeN), .outputDriveN(outputDriveN),
		.addrIn(addrOut), .dqIn(dqWire), .dqOut(memDq), .dqEn(memEn));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One request; keep leaves valid up for a back-to-back page hit
	task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d, input logic keep);
		int n;
		n = 0;
		#1 reqValid = 1'h1;
		req = {w, a, d};
		@(posedge clk_sys);
		while (reqReady !== 1'h1 && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		#1 reqValid = keep;
		n = 0;
		@(posedge clk_sys);
		while (rspValid !== 1'h1 && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		chk({7'h00, rspValid}, 8'h01);
		if (!w) chk(rspData, d);
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************
	// Sequence
	// ****************
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		clk_sys = 1'h0;
		srst = 1'h1;
		clkEn = 1'h1;
		reqValid = 1'h0;
		req = '0;
		repeat (20) @(posedge clk_sys);
		chk({5'h00, reqReady, selLowN, dataOeN}, 8'h03);
		#1 srst = 1'h0;
		foreach (rows[i]) op(rows[i].w, rows[i].a, rows[i].d, 1'h0);
		// Row opened by the first write, then page hits with the request held between bytes
		op(1'h1, 17'h00010, 8'h11, 1'h1);
		op(1'h1, 17'h00013, 8'h22, 1'h1);
		op(1'h0, 17'h00010, 8'h11, 1'h1);
		op(1'h0, 17'h00013, 8'h22, 1'h0);
		// Reset in mid read; array keeps its contents
		#1 reqValid = 1'h1;
		req = {1'h0, 17'h00008, 8'h00};
		repeat (4) @(posedge clk_sys);
		#1 srst = 1'h1;
		reqValid = 1'h0;
		repeat (2) @(posedge clk_sys);
		chk({4'h0, selLowN, writeStrobeN, outputDriveN, reqReady}, 8'h0e);
		#1 srst = 1'h0;
		@(posedge clk_sys);
		op(1'h0, 17'h00008, 8'he7, 1'h0);
		// Frozen controller must ignore a pending write
		#1 clkEn = 1'h0;
		reqValid = 1'h1;
		req = {1'h1, 17'h00008, 8'h99};
		repeat (3) @(posedge clk_sys);
		chk({5'h00, reqReady, selLowN, writeStrobeN}, 8'h05);
		#1 clkEn = 1'h1;
		reqValid = 1'h0;
		op(1'h0, 17'h00008, 8'he7, 1'h0);
		report_and_stop();
	end
endmodule
